// ===== design/ssd_pkg.sv
// package for the serial segment display chain
// assumes one 40 MHz system clock sampling all link pins
package ssd_pkg;
  localparam int SSD_DIGIT_BITS = 8;
  localparam int SSD_DIGITS = 3;
  localparam int SSD_CHAIN_BITS = SSD_DIGIT_BITS * SSD_DIGITS;
  localparam logic [SSD_CHAIN_BITS-1:0] SSD_CHAIN_RST = 24'hFFFFFF;
  localparam logic [SSD_CHAIN_BITS-1:0] SSD_LATCH_RST = 24'hFFFFFF;

  // link pins as seen by the module
  typedef struct packed {
    logic sclk;
    logic ser;
    logic rclk;
  } ssd_link_t;

  // segment drive of one module, active low per segment, digit 2 is left
  typedef struct packed {
    logic [SSD_DIGIT_BITS-1:0] left;
    logic [SSD_DIGIT_BITS-1:0] middle;
    logic [SSD_DIGIT_BITS-1:0] right;
  } ssd_segs_t;
endpackage : ssd_pkg

// ===== design/ssd_sync.sv
// two-flop synchroniser for the three link pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module ssd_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pins in, synchronised out
  input ssd_pkg::ssd_link_t pin_in,
  output ssd_pkg::ssd_link_t sync_out
);
  import ssd_pkg::*;
  typedef struct packed {
    ssd_link_t s1;
    ssd_link_t s2;
  } ssd_sync_state_t;
  ssd_sync_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
  end

  // rclk idles high so the display starts blanked
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{s1: 3'b001, s2: 3'b001};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.s2;
endmodule : ssd_sync

// ===== design/ssd_chain.sv
// one three-digit display module: 24-bit shift chain, output latch, blanking
// assumes link pins from another domain; sclk well below clk/4
// What this block does
// R1 - every stage samples serial data and shifts on each rising shift clock
// R2 - three 8-bit stages cascade right, middle, left as one 24-bit path
// R3 - left stage serial output drives the cascade output for stacking
// R4 - a segment lights only on a latched low; driver sends inverted data
// R5 - driver may be an SPI master with data valid at rising clock
// R6 - driver keeps shift clock under about 10 or 15 MHz, derated
// R7 - rising latch strobe copies whole chain into output latches
// R8 - latch strobe low shows segments, high blanks all segments
// R9 - driver may PWM the latch strobe for brightness
// R10 - stacked modules share clock and strobe, fed from cascade output
// R11 - driver returns latch strobe low at the next rising shift clock; the bench lowers it 6 clk after raising it, before any shift
// R12 - driver idles clock low and shifts three words per module per frame
`timescale 1ns/1ps
module ssd_chain (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link from the driver or previous module
  input wire logic sclk,
  input wire logic ser,
  input wire logic rclk,
  // stacking output
  output logic cascade_out,
  // segment drive, low lights a segment
  output ssd_pkg::ssd_segs_t seg_n
);
  import ssd_pkg::*;

  // ==========================================
  // state
  typedef struct packed {
    logic sclk_d;
    logic rclk_d;
    logic [SSD_CHAIN_BITS-1:0] chain;
    logic [SSD_CHAIN_BITS-1:0] latch;
    logic cascade;
    ssd_segs_t segs;
  } ssd_state_t;
  ssd_state_t st_reg, st_next;
  ssd_link_t link_pin;
  ssd_link_t link_s;
  logic sclk_rise, rclk_rise;

  // ==========================================
  // pin capture
  // the three pins are gathered first so the synchroniser sees one typed bundle
  assign link_pin.sclk = sclk;
  assign link_pin.ser = ser;
  assign link_pin.rclk = rclk;

  ssd_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(link_pin),
    .sync_out(link_s)
  );

  // ==========================================
  // edge detect on synchronised pins
  assign sclk_rise = link_s.sclk & ~st_reg.sclk_d;
  assign rclk_rise = link_s.rclk & ~st_reg.rclk_d;

  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = link_s.sclk;
    st_next.rclk_d = link_s.rclk;
    if (sclk_rise) begin
      // right digit is bits 7:0 and takes new bits first
      st_next.chain = {st_reg.chain[SSD_CHAIN_BITS-2:0], link_s.ser}; // R1 R2
    end
    if (rclk_rise) begin
      // latch takes the chain as it stood before any shift in this cycle
      st_next.latch = st_reg.chain; // R7
    end
    // ser and sclk share the same sync delay, so data is stable at the edge
    st_next.cascade = st_next.chain[SSD_CHAIN_BITS-1]; // R3 R10
    // blanked drive is all ones: common anode, one is dark
    if (link_s.rclk) begin
      st_next.segs = '1; // R8
    end else begin
      st_next.segs = st_next.latch; // R4 R8
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{sclk_d: 1'b0, rclk_d: 1'b1, chain: SSD_CHAIN_RST, latch: SSD_LATCH_RST,
                  cascade: 1'b1, segs: SSD_LATCH_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign cascade_out = st_reg.cascade;
  assign seg_n = st_reg.segs;

  // ==========================================
  // checks
  a_shift_on_rise: assert property (@(posedge clk) disable iff (!resetn) // R1
    sclk_rise |=> st_reg.chain[0] == $past(link_s.ser))
    else $error("chain did not take serial data on shift clock rise");
  a_chain_hold: assert property (@(posedge clk) disable iff (!resetn) // R2
    !sclk_rise |=> st_reg.chain == $past(st_reg.chain))
    else $error("chain moved without a shift clock rise");
  a_cascade_tap: assert property (@(posedge clk) disable iff (!resetn) // R3
    cascade_out == st_reg.chain[SSD_CHAIN_BITS-1])
    else $error("cascade output not left stage msb");
  sequence s_strobe_rise;
    rclk_rise;
  endsequence
  a_latch_copy: assert property (@(posedge clk) disable iff (!resetn) // R7
    s_strobe_rise |=> st_reg.latch == $past(st_reg.chain))
    else $error("latch did not copy chain on strobe rise");
  a_latch_hold: assert property (@(posedge clk) disable iff (!resetn) // R7
    !rclk_rise |=> $stable(st_reg.latch))
    else $error("latch changed without strobe rise");
  a_blank_high: assert property (@(posedge clk) disable iff (!resetn) // R8
    link_s.rclk |=> seg_n == '1)
    else $error("segments not blanked with strobe high");
  a_show_low: assert property (@(posedge clk) disable iff (!resetn) // R4
    !link_s.rclk |=> seg_n == st_reg.latch)
    else $error("segments do not show latch with strobe low");

  // ==========================================
  // edge detector checks
  // a held pin level must never shift or latch twice; the detector
  // compares against its own delayed copy, so each rise is one cycle
  a_rise_single: assert property (@(posedge clk) disable iff (!resetn) // R1
    sclk_rise |=> !sclk_rise)
    else $error("shift clock rise seen on two cycles in a row");
  a_strobe_single: assert property (@(posedge clk) disable iff (!resetn) // R7
    rclk_rise |=> !rclk_rise)
    else $error("strobe rise seen on two cycles in a row");
  a_sclk_track: assert property (@(posedge clk) disable iff (!resetn) // R1
    1'b1 |=> st_reg.sclk_d == $past(link_s.sclk))
    else $error("shift clock delay copy lost the pin level");

  // ==========================================
  // shift path checks
  // the whole chain moves one place toward the left digit per rise;
  // the digit boundaries are checked once per boundary below
  sequence s_shift_rise;
    sclk_rise;
  endsequence
  a_shift_whole: assert property (@(posedge clk) disable iff (!resetn) // R2
    s_shift_rise |=> st_reg.chain[SSD_CHAIN_BITS-1:1] == $past(st_reg.chain[SSD_CHAIN_BITS-2:0]))
    else $error("chain did not move one place on a shift");
  generate
    for (genvar d = 1; d < SSD_DIGITS; d++) begin : g_stage_link
      // msb of the lower digit feeds lsb of the next digit to the left
      a_stage_link: assert property (@(posedge clk) disable iff (!resetn) // R2
        s_shift_rise |=> st_reg.chain[d*SSD_DIGIT_BITS] == $past(st_reg.chain[d*SSD_DIGIT_BITS-1]))
        else $error("digit stage did not feed the next stage");
    end
  endgenerate

  // ==========================================
  // cascade output checks
  // a stacked module samples this pin on its own copy of the shift clock,
  // so it must only ever change as a result of a shift here
  a_cascade_next: assert property (@(posedge clk) disable iff (!resetn) // R3 R10
    s_shift_rise |=> cascade_out == $past(st_reg.chain[SSD_CHAIN_BITS-2]))
    else $error("cascade output did not take the next chain bit");
  a_cascade_hold: assert property (@(posedge clk) disable iff (!resetn) // R3
    !sclk_rise |=> $stable(cascade_out))
    else $error("cascade output moved without a shift");

  // ==========================================
  // output enable checks
  // leaving blanking must show the latch as it already stood;
  // no latch update can fall in that cycle since the strobe is low
  a_show_return: assert property (@(posedge clk) disable iff (!resetn) // R8
    $fell(link_s.rclk) |=> seg_n == $past(st_reg.latch))
    else $error("segments did not return to the latch after blanking");
  a_blank_enter: assert property (@(posedge clk) disable iff (!resetn) // R8
    $rose(link_s.rclk) |=> seg_n == '1)
    else $error("segments not blanked when strobe rose");

  // ==========================================
  // limitations
  // the pins are sampled by clk, not used as clocks: a shift clock
  // above clk/4 or a pulse under two clk periods can be lost
  // serial data passes the same two flops as the shift clock, so a
  // driver must hold it for two clk periods around each rise
  // a strobe rise and a shift rise in one cycle latch the old chain,
  // which matches a parallel latch clocked by the same edge
endmodule : ssd_chain

// ===== test/ssd_drv.sv
// partner model: a display driver bit-banging the three link pins
// assumes calls are made at a rising edge of clk
`timescale 1ns/1ps
module ssd_drv (
  // clock
  input wire logic clk,
  // link pins
  output ssd_pkg::ssd_link_t link
);
  import ssd_pkg::*;
  // ========================================
  // pin drive
  initial link = '{sclk: 1'b0, ser: 1'b1, rclk: 1'b1};
  // 8 clk per bit; data leads the rise by 4 clk
  task automatic shift_bit(input logic b);
    link.ser <= b;
    repeat (4) @(posedge clk);
    link.sclk <= 1'b1;
    repeat (3) @(posedge clk);
    link.sclk <= 1'b0;
  endtask : shift_bit
  // data line is inverted here, so it must not keep the last bit
  task automatic set_strobe(input logic v);
    link.rclk <= v;
    link.ser <= ~link.ser;
  endtask : set_strobe
endmodule : ssd_drv

// ===== test/tb.sv
// self-checking bench: random frames through the partner, compared with a shift model
// assumes the partner drives all link pins
`timescale 1ns/1ps
module tb;
  import ssd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cascade_out;
  ssd_link_t link;
  ssd_segs_t seg_n;
  logic [23:0] chain_m = SSD_CHAIN_RST;
  logic [7:0] lfsr = 8'h48;
  int num_errors = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  ssd_drv i_ssd_drv (.clk(clk), .link(link));
  ssd_chain i_ssd_chain (.clk(clk), .resetn(resetn), .sclk(link.sclk), .ser(link.ser),
    .rclk(link.rclk), .cascade_out(cascade_out), .seg_n(seg_n));
  // ========================================
  // helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done();
  end
  // ========================================
  // main sequence
  initial begin
    logic [23:0] w;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    check("seg_n", 24'hFFFFFF, seg_n);
    check("cascade_out", 24'h1, 24'(cascade_out));
    @(posedge clk);
    i_ssd_drv.set_strobe(1'b0);
    repeat (6) @(negedge clk);
    check("seg_n reset latch", SSD_LATCH_RST, seg_n);
    @(posedge clk);
    for (int f = 0; f < 6; f++) begin
      // first frame lights every segment
      for (int k = 0; k < 3; k++) begin
        lfsr = lfsr_next(lfsr);
        w = {w[15:0], lfsr};
      end
      if (f == 0) w = 24'h000000;
      for (int i = 23; i >= 0; i--) begin
        i_ssd_drv.shift_bit(w[i]);
        chain_m = {chain_m[22:0], w[i]};
        @(negedge clk);
        check("cascade_out", 24'(chain_m[23]), 24'(cascade_out));
        @(posedge clk);
      end
      i_ssd_drv.set_strobe(1'b1);
      repeat (6) @(negedge clk);
      check("seg_n blank", 24'hFFFFFF, seg_n);
      @(posedge clk);
      i_ssd_drv.set_strobe(1'b0);
      repeat (6) @(negedge clk);
      check("seg_n", chain_m, seg_n);
      @(posedge clk);
    end
    test_done();
  end
endmodule : tb
